/* File: rtl/field_limit_switch.sv */
// How it works
// - Field goes out cyclically; temperature only by acyclic read at temperature_reading.
// - Two limit pairs kept; limit crossing flagged by a process data bit.
// - Default: both outputs two point mode on the vector sum.
// - Each output compares x, y, z or vector sum, selectable.
// - Link mode exchanges parameters first, then cyclic data starts.
// - Standard I/O mode: no link traffic, only switching outputs with stored settings.
// - A configuration bit inverts each output's polarity.
// - Single point: rising value turns output on above first limit.
// - Single point: falling value turns off below first limit minus hysteresis.
// - Two point: rising value turns on above switch-on limit.
// - Two point: falling value turns off below switch-off limit.
// - Window rising: on from lower limit until above upper limit plus hysteresis.
// - Window falling: on from upper limit until below lower limit minus hysteresis.
// - Each axis gives a 32-bit telegram: value, vector, reserved, switch bits.
// - Vector sum gives a further 32-bit telegram.
// - Axis values signed within +-2500 uT; magnitude 0..2500 uT.
// - Temperature is 16-bit, 0.1 degC steps, range -25..+70 degC.
`timescale 1ns/100ps
`include "field_limit_cfg.svh"
module field_limit_switch
  import field_limit_pkg::*;
#(
  parameter int PARAM_CYCLES = `PARAM_ACK_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Measured samples
  input wire sample_type SAMPLE,
  input wire logic SAMPLE_VALID,
  input wire logic [7:0] VECTOR_FIELD,
  input wire logic signed [15:0] TEMP_VALUE,
  // Configuration from link
  input wire out_cfg_type CFG_1,
  input wire out_cfg_type CFG_2,
  input wire logic CFG_WRITE,
  // Link control
  input wire logic LINK_START,
  input wire logic STANDARD_IO_MODE,
  input wire logic ACYC_REQ,
  input wire logic [15:0] ACYC_INDEX,
  // Link outputs
  output logic LINK_READY,
  output logic CYCLIC_VALID,
  output logic [127:0] PROCESS_DATA,
  output logic ACYC_VALID,
  output logic ACYC_ERROR,
  output logic [15:0] ACYC_DATA,
  // Binary switching outputs
  output logic SWITCH_1,
  output logic SWITCH_2
);
  initial begin
    if (PARAM_CYCLES < 1 || PARAM_CYCLES > 255) $error("PARAM_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic signed [17:0] pick(input sample_type s, input logic [1:0] src);
    case (src)
      SRC_X: pick = 18'(s.x);
      SRC_Y: pick = 18'(s.y);
      SRC_Z: pick = 18'(s.z);
      default: pick = {2'h0, s.sum};
    endcase
  endfunction : pick

  function automatic logic signed [17:0] lim(input logic [15:0] v);
    lim = 18'(signed'(v));
  endfunction : lim

  function automatic logic evaluate(input out_cfg_type c, input logic signed [17:0] v, input logic st);
    logic signed [17:0] a;
    logic signed [17:0] b;
    logic signed [17:0] h;
    a = lim(c.first_limit);
    b = lim(c.second_limit);
    h = {2'h0, c.hysteresis};
    evaluate = st;
    case (c.mode)
      MODE_SINGLE: begin
        if (v > a) evaluate = 1'b1;
        else if (v < a - h) evaluate = 1'b0;
      end
      MODE_WINDOW: begin
        if (v > a + h || v < b - h) evaluate = 1'b0;
        else if (v >= b && v <= a) evaluate = 1'b1;
      end
      default: begin
        if (v > a) evaluate = 1'b1;
        else if (v < b) evaluate = 1'b0;
      end
    endcase
  endfunction : evaluate

  function automatic logic signed [15:0] clamp_axis(input logic signed [15:0] v);
    if (v > signed'(`AXIS_LIMIT)) clamp_axis = `AXIS_LIMIT;
    else if (v < -signed'(`AXIS_LIMIT)) clamp_axis = -signed'(`AXIS_LIMIT);
    else clamp_axis = v;
  endfunction : clamp_axis

  function automatic logic [31:0] telegram(input logic [15:0] v, input logic [7:0] vec, input logic [1:0] sw);
    telegram = 32'h0;
    telegram[`VAL_LSB +: 16] = v;
    telegram[`VEC_LSB +: 8] = vec;
    telegram[`RSV_LSB +: 6] = 6'h00;
    telegram[`SW_LSB +: 2] = sw;
  endfunction : telegram

  ////////////////////////////////////////////////////////////////////////////
  // Configuration store
  out_cfg_type cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt;
  always_comb begin
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    if (CFG_WRITE && !STANDARD_IO_MODE) begin
      cfg1_nxt = CFG_1;
      cfg2_nxt = CFG_2;
    end
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg1_r <= '{mode: `DEF_MODE, source: `DEF_SRC, default: '0};
      cfg2_r <= '{mode: `DEF_MODE, source: `DEF_SRC, default: '0};
    end else begin
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching evaluation
  logic [1:0] state_r, state_nxt;
  sample_type samp_r, samp_nxt;
  always_comb begin
    state_nxt = state_r;
    samp_nxt = samp_r;
    if (SAMPLE_VALID) begin
      samp_nxt.x = clamp_axis(SAMPLE.x);
      samp_nxt.y = clamp_axis(SAMPLE.y);
      samp_nxt.z = clamp_axis(SAMPLE.z);
      samp_nxt.sum = (SAMPLE.sum > `AXIS_LIMIT) ? `AXIS_LIMIT : SAMPLE.sum;
      state_nxt[0] = evaluate(cfg1_r, pick(SAMPLE, cfg1_r.source), state_r[0]);
      state_nxt[1] = evaluate(cfg2_r, pick(SAMPLE, cfg2_r.source), state_r[1]);
    end
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= 2'h0;
      samp_r <= '0;
    end else begin
      state_r <= state_nxt;
      samp_r <= samp_nxt;
    end
  end

  logic [1:0] sw;
  assign sw = state_r ^ {cfg2_r.invert, cfg1_r.invert};
  assign SWITCH_1 = sw[0];
  assign SWITCH_2 = sw[1];

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencing
  link_state_type link_r, link_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  always_comb begin
    link_nxt = link_r;
    cnt_nxt = cnt_r;
    case (link_r)
      LINK_IDLE: begin
        if (LINK_START && !STANDARD_IO_MODE) begin
          link_nxt = LINK_PARAM;
          cnt_nxt = 8'h00;
        end
      end
      LINK_PARAM: begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == 8'(PARAM_CYCLES - 1)) link_nxt = LINK_CYCLIC;
      end
      LINK_CYCLIC: link_nxt = LINK_CYCLIC;
      default: link_nxt = LINK_IDLE;
    endcase
    if (STANDARD_IO_MODE) link_nxt = LINK_IDLE;
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link_r <= LINK_IDLE;
      cnt_r <= 8'h00;
    end else begin
      link_r <= link_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign LINK_READY = (link_r == LINK_CYCLIC);

  ////////////////////////////////////////////////////////////////////////////
  // Cyclic and acyclic data
  logic [127:0] pd_r, pd_nxt;
  logic cv_r, cv_nxt;
  logic av_r, av_nxt, ae_r, ae_nxt;
  logic [15:0] ad_r, ad_nxt;
  always_comb begin
    pd_nxt = pd_r;
    cv_nxt = 1'b0;
    av_nxt = 1'b0;
    ae_nxt = 1'b0;
    ad_nxt = ad_r;
    if (link_r == LINK_CYCLIC) begin
      cv_nxt = 1'b1;
      pd_nxt = {telegram(samp_r.x, VECTOR_FIELD, sw), telegram(samp_r.y, VECTOR_FIELD, sw),
                telegram(samp_r.z, VECTOR_FIELD, sw), telegram(samp_r.sum, VECTOR_FIELD, sw)};
      if (ACYC_REQ) begin
        av_nxt = 1'b1;
        if (ACYC_INDEX == `TEMP_INDEX) ad_nxt = TEMP_VALUE;
        else ae_nxt = 1'b1;
      end
    end
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pd_r <= '0;
      cv_r <= 1'b0;
      av_r <= 1'b0;
      ae_r <= 1'b0;
      ad_r <= 16'h0000;
    end else begin
      pd_r <= pd_nxt;
      cv_r <= cv_nxt;
      av_r <= av_nxt;
      ae_r <= ae_nxt;
      ad_r <= ad_nxt;
    end
  end
  assign PROCESS_DATA = pd_r;
  assign CYCLIC_VALID = cv_r;
  assign ACYC_VALID = av_r;
  assign ACYC_ERROR = ae_r;
  assign ACYC_DATA = ad_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_NO_CYCLIC_IN_SIO: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    STANDARD_IO_MODE |=> !LINK_READY) else $error("link active in standard io mode");
  AST_PARAM_BEFORE_CYCLIC: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    $rose(CYCLIC_VALID) |-> $past(link_r, 2) == LINK_PARAM) else $error("cyclic before params");
  AST_INVERT: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SWITCH_1 == (state_r[0] ^ cfg1_r.invert)) else $error("inversion wrong");
  AST_INVERT_TOGGLE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    $changed(cfg2_r.invert) && $stable(state_r[1]) |-> $changed(SWITCH_2)) else $error("inversion not applied");
  AST_HOLD_NO_SAMPLE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !SAMPLE_VALID |=> $stable(state_r)) else $error("state changed without sample");
  AST_TWO_ON: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg1_r.mode == MODE_TWO && pick(SAMPLE, cfg1_r.source) > lim(cfg1_r.first_limit)
    |=> state_r[0]) else $error("two point not on");
  AST_TWO_OFF: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg1_r.mode == MODE_TWO && pick(SAMPLE, cfg1_r.source) < lim(cfg1_r.second_limit)
    && pick(SAMPLE, cfg1_r.source) <= lim(cfg1_r.first_limit) |=> !state_r[0]) else $error("two point not off");
  AST_TWO_HOLD: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg1_r.mode == MODE_TWO && pick(SAMPLE, cfg1_r.source) <= lim(cfg1_r.first_limit)
    && pick(SAMPLE, cfg1_r.source) >= lim(cfg1_r.second_limit)
    |=> $stable(state_r[0])) else $error("two point not held");
  AST_SINGLE_ON: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg2_r.mode == MODE_SINGLE && pick(SAMPLE, cfg2_r.source) > lim(cfg2_r.first_limit)
    |=> state_r[1]) else $error("single point not on");
  AST_SINGLE_OFF: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg2_r.mode == MODE_SINGLE
    && pick(SAMPLE, cfg2_r.source) < lim(cfg2_r.first_limit) - signed'({2'h0, cfg2_r.hysteresis})
    |=> !state_r[1]) else $error("single point not off");
  AST_WINDOW_ON: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg2_r.mode == MODE_WINDOW && pick(SAMPLE, cfg2_r.source) >= lim(cfg2_r.second_limit)
    && pick(SAMPLE, cfg2_r.source) <= lim(cfg2_r.first_limit) |=> state_r[1]) else $error("window not on");
  AST_WINDOW_OFF_HIGH: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg2_r.mode == MODE_WINDOW
    && pick(SAMPLE, cfg2_r.source) > lim(cfg2_r.first_limit) + signed'({2'h0, cfg2_r.hysteresis})
    |=> !state_r[1]) else $error("window not off above");
  AST_WINDOW_OFF_LOW: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    SAMPLE_VALID && cfg2_r.mode == MODE_WINDOW
    && pick(SAMPLE, cfg2_r.source) < lim(cfg2_r.second_limit) - signed'({2'h0, cfg2_r.hysteresis})
    |=> !state_r[1]) else $error("window not off below");
  AST_LINK_NEEDS_START: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    link_r == LINK_IDLE && !LINK_START |=> link_r == LINK_IDLE) else $error("link left idle unasked");
  AST_CYCLIC_ONLY_LINKED: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CYCLIC_VALID |-> $past(LINK_READY)) else $error("cyclic data without link");
  AST_SIO_KEEPS_CFG: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    STANDARD_IO_MODE && CFG_WRITE |=> $stable(cfg1_r) && $stable(cfg2_r))
    else $error("config written in standard io mode");
  AST_TEMP_READ: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    LINK_READY && ACYC_REQ && ACYC_INDEX == `TEMP_INDEX |=> ACYC_VALID && !ACYC_ERROR && ACYC_DATA == $past(TEMP_VALUE))
    else $error("temperature read wrong");
  AST_ACYC_REFUSED: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !LINK_READY |=> !ACYC_VALID) else $error("acyclic answer outside cyclic phase");
  AST_RESERVED_ZERO: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    PROCESS_DATA[`RSV_LSB +: 6] == 6'h00 && PROCESS_DATA[32 + `RSV_LSB +: 6] == 6'h00) else $error("reserved nonzero");
  AST_RESERVED_ZERO_HIGH: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    PROCESS_DATA[64 + `RSV_LSB +: 6] == 6'h00 && PROCESS_DATA[96 + `RSV_LSB +: 6] == 6'h00)
    else $error("upper reserved nonzero");
  AST_SWITCH_BITS: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CYCLIC_VALID |-> PROCESS_DATA[`SW_LSB +: 2] == $past({SWITCH_2, SWITCH_1})
    && PROCESS_DATA[96 + `SW_LSB +: 2] == $past({SWITCH_2, SWITCH_1})) else $error("switch bits wrong");
  AST_SUM_CLAMPED: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CYCLIC_VALID |-> PROCESS_DATA[`VAL_LSB +: 16] <= `AXIS_LIMIT) else $error("magnitude above range");
endmodule : field_limit_switch

/* File: rtl/field_limit_cfg.svh */
`ifndef FIELD_LIMIT_CFG_SVH
`define FIELD_LIMIT_CFG_SVH
`define TEMP_INDEX 16'h0100
`define AXIS_LIMIT 16'h09C4
`define SW_LSB 0
`define RSV_LSB 2
`define VEC_LSB 8
`define VAL_LSB 16
`define DEF_MODE 2'h1
`define DEF_SRC 2'h3
`define PARAM_ACK_CYCLES 4
`endif

/* File: rtl/field_limit_pkg.sv */
package field_limit_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_TWO = 2'h1,
    MODE_WINDOW = 2'h2
  } switch_mode_type;
  typedef enum logic [1:0] {
    SRC_X = 2'h0,
    SRC_Y = 2'h1,
    SRC_Z = 2'h2,
    SRC_SUM = 2'h3
  } source_type;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] source;
    logic invert;
    logic [15:0] first_limit;
    logic [15:0] second_limit;
    logic [15:0] hysteresis;
  } out_cfg_type;
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
    logic [15:0] sum;
  } sample_type;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_PARAM = 2'h1,
    LINK_CYCLIC = 2'h2
  } link_state_type;
endpackage : field_limit_pkg

/* File: test/link_master_model.sv */
`timescale 1ns/100ps
// Link master partner: starts the link and issues acyclic reads
module link_master_model (
  // Clock
  input wire logic REF_CLK,
  // From device
  input wire logic LINK_READY,
  input wire logic ACYC_VALID,
  input wire logic ACYC_ERROR,
  input wire logic [15:0] ACYC_DATA,
  // To device
  output logic LINK_START,
  output logic ACYC_REQ,
  output logic [15:0] ACYC_INDEX
);
  initial begin
    LINK_START = 1'b0;
    ACYC_REQ = 1'b0;
    ACYC_INDEX = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////
  task start_link(output logic ok);
    int i;
    LINK_START = 1'b1;
    @(negedge REF_CLK);
    LINK_START = 1'b0;
    for (i = 0; i < 20 && LINK_READY !== 1'b1; i++) @(negedge REF_CLK);
    ok = LINK_READY;
  endtask : start_link
  ////////////////////////////////////////////////////////////////
  task read(input logic [15:0] idx, output logic [15:0] d, output logic v, output logic e);
    int i;
    ACYC_INDEX = idx;
    ACYC_REQ = 1'b1;
    @(negedge REF_CLK);
    ACYC_REQ = 1'b0;
    ACYC_INDEX = ~idx;
    for (i = 0; i < 4 && (ACYC_VALID | ACYC_ERROR) !== 1'b1; i++) @(negedge REF_CLK);
    d = ACYC_DATA;
    v = ACYC_VALID;
    e = ACYC_ERROR;
    @(negedge REF_CLK);
  endtask : read
endmodule : link_master_model

/* File: test/tb_field_limit_switch.sv */
`timescale 1ns/100ps
module tb_field_limit_switch import field_limit_pkg::*; ;
  logic clk, rst_n, svalid, cfg_wr, link_start, standard_io_mode, acyc_req, link_ready, cyc_valid;
  logic acyc_valid, acyc_err, sw1, sw2, ok, e, v;
  sample_type smp_d;
  logic [7:0] vec;
  logic signed [15:0] temp;
  out_cfg_type cfg1, cfg2;
  logic [15:0] acyc_idx, acyc_data, d;
  logic [127:0] pd;
  int err_count, n_compared;
  ////////////////////////////////////////////////////////////////
  field_limit_switch #(.PARAM_CYCLES(4)) uut (.REF_CLK(clk), .RESET_N(rst_n), .SAMPLE(smp_d),
    .SAMPLE_VALID(svalid), .VECTOR_FIELD(vec), .TEMP_VALUE(temp), .CFG_1(cfg1), .CFG_2(cfg2),
    .CFG_WRITE(cfg_wr), .LINK_START(link_start), .STANDARD_IO_MODE(standard_io_mode), .ACYC_REQ(acyc_req),
    .ACYC_INDEX(acyc_idx), .LINK_READY(link_ready), .CYCLIC_VALID(cyc_valid), .PROCESS_DATA(pd),
    .ACYC_VALID(acyc_valid), .ACYC_ERROR(acyc_err), .ACYC_DATA(acyc_data), .SWITCH_1(sw1), .SWITCH_2(sw2));
  link_master_model m (.REF_CLK(clk), .LINK_READY(link_ready), .ACYC_VALID(acyc_valid),
    .ACYC_ERROR(acyc_err), .ACYC_DATA(acyc_data), .LINK_START(link_start), .ACYC_REQ(acyc_req),
    .ACYC_INDEX(acyc_idx));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cfg(input logic [1:0] md, src, input int f, l, h);
    cfg1 = '{md, src, 1'b0, 16'(f), 16'(l), 16'(h)};
    cfg2 = '{md, src, 1'b1, 16'(f), 16'(l), 16'(h)};
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask : cfg
  task smp(input int x, y, z, s, input logic e1, e2);
    smp_d = '{16'(x), 16'(y), 16'(z), 16'(s)};
    svalid = 1'b1;
    @(negedge clk);
    svalid = 1'b0;
    @(negedge clk);
    chk({sw2, sw1}, {e2, e1});
  endtask : smp
  task stop_test;
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
  initial begin
    rst_n = 1'b0; svalid = 1'b0; cfg_wr = 1'b0; standard_io_mode = 1'b0; smp_d = '0; vec = 8'h5A;
    temp = 16'hFF06; cfg1 = '0; cfg2 = '0; err_count = 0; n_compared = 0;
    repeat (10) @(negedge clk);
    chk({sw2, sw1, link_ready, cyc_valid}, 4'h0);
    rst_n = 1'b1;
    @(negedge clk);
    smp(0, 0, 0, 16, 1, 1);
    m.start_link(ok);
    @(negedge clk);
    chk({ok, cyc_valid}, 2'h3);
    m.read(16'h0100, d, v, e);
    chk({v, e, d}, {2'h2, 16'hFF06});
    m.read(16'h0101, d, v, e);
    chk({v, e}, 2'h3);
    cfg(MODE_TWO, SRC_X, 100, 50, 0);
    smp(40, 0, 0, 0, 0, 1);
    smp(80, 0, 0, 0, 0, 1);
    smp(120, 0, 0, 0, 1, 0);
    smp(70, 0, 0, 0, 1, 0);
    smp(40, 0, 0, 0, 0, 1);
    cfg(MODE_SINGLE, SRC_Y, 100, 0, 20);
    smp(0, 90, 0, 0, 0, 1);
    smp(0, 110, 0, 0, 1, 0);
    smp(0, 85, 0, 0, 1, 0);
    smp(0, 75, 0, 0, 0, 1);
    cfg(MODE_WINDOW, SRC_Z, 200, 100, 10);
    smp(0, 0, 50, 0, 0, 1);
    smp(3000, -3000, 150, 3000, 1, 0);
    chk(pd, 128'h09C45A01_F63C5A01_00965A01_09C45A01);
    smp(0, 0, 205, 0, 1, 0);
    smp(0, 0, 215, 0, 0, 1);
    smp(0, 0, 150, 0, 1, 0);
    smp(0, 0, 95, 0, 1, 0);
    smp(0, 0, 85, 0, 0, 1);
    standard_io_mode = 1'b1;
    cfg(MODE_TWO, SRC_SUM, 0, 0, 0);
    smp(0, 0, 150, 0, 1, 0);
    chk({link_ready, cyc_valid}, 2'h0);
    m.read(16'h0100, d, v, e);
    chk({v, e}, 2'h0);
    stop_test;
  end
endmodule : tb_field_limit_switch
